/* File: core/dac_reset_latch_ctrl.sv */
`timescale 1ns/1ps
// Function
// [R1] power-on loads offset, data, latches from select
// [R2] input data register clears on any reset
// [R3] dual-supply data and offset reset code table
// [R4] single supply disables offset DAC, same codes
// [R5] power-on restores gain and zero defaults
// [R6] hardware reset forces codes and gain/zero defaults
// [R7] hardware reset disables serial port, output hi-z
// [R8] after reset release, hold codes until reprogrammed
// [R9] host keeps chip select high around reset; the testbench drives a frame with chip select low in reset
// [R10] update mode strapped from load strobe at power-on
// [R11] load updates only channels written since last load
// [R12] latch update changes output at once
// [R13] asynchronous mode ignores strobe and software load
// [R14] async, engine off: update on chip select rise
// [R15] async, engine on: update when engine writes channel
// [R16] sync, engine off: load updates pending latches together
// [R17] sync, engine on: load waits for engine finish
// [R18] sync, no load: latches and outputs unchanged
// [R19] host loads only after spacing from chip select
// [R20] spacing counted in cycles, per-channel pending flags
module dac_reset_latch_ctrl (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic clk_en,
  // straps and control pins
  input wire logic hw_reset_n,
  input wire logic reset_value_select,
  input wire logic input_format_select,
  input wire logic single_supply,
  input wire logic latch_load_strobe_n,
  input wire logic software_load_bit,
  input wire logic correction_engine_enable,
  // decoded serial frame
  input wire logic cs_n,
  input wire logic frame_valid,
  input wire dac_rst_pkg::target_t frame_target,
  input wire dac_rst_pkg::chan_t frame_ch,
  input wire dac_rst_pkg::code_t frame_data,
  input wire logic sdo_drive,
  // correction engine
  output logic corr_start,
  output dac_rst_pkg::chan_t corr_ch,
  output dac_rst_pkg::code_t corr_code,
  input wire logic corr_done,
  input wire dac_rst_pkg::chan_t corr_done_ch,
  input wire dac_rst_pkg::code_t corr_result,
  // status
  output logic serial_enable,
  output logic sdo_oe_n,
  output logic sync_mode,
  output logic offset_dac_enable,
  output dac_rst_pkg::code_t offset_code_a,
  output dac_rst_pkg::code_t offset_code_b,
  // per-channel codes
  output dac_rst_pkg::code_t input_code [dac_rst_pkg::NUM_CH],
  output dac_rst_pkg::code_t data_code [dac_rst_pkg::NUM_CH],
  output dac_rst_pkg::code_t latch_code [dac_rst_pkg::NUM_CH],
  output dac_rst_pkg::code_t gain_code [dac_rst_pkg::NUM_CH],
  output dac_rst_pkg::code_t zero_code [dac_rst_pkg::NUM_CH],
  output logic [dac_rst_pkg::NUM_CH-1:0] pending
);
  import dac_rst_pkg::*;

  load_if lif();

  logic in_reset;
  logic cs_q;
  logic cs_rise;
  logic wr_acc;
  logic data_wr;
  logic por_done;
  logic [BUSY_W-1:0] busy;
  logic [NUM_CH-1:0] latch_upd;
  code_t rst_code;
  code_t rst_offset;
  logic next_cs_q;
  logic next_por_done;
  logic next_sync_mode;
  logic next_corr_start;
  chan_t next_corr_ch;
  code_t next_corr_code;
  logic [BUSY_W-1:0] next_busy;
  code_t next_offset;

  load_timer u_timer (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .clk_en(clk_en),
    .latch_load_strobe_n(latch_load_strobe_n),
    .software_load_bit(software_load_bit),
    .lif(lif)
  );

  // reset, serial gating and frame acceptance
  assign in_reset = !rstn || !hw_reset_n; // [R6]
  assign serial_enable = rstn && hw_reset_n; // [R7] [R8]
  assign sdo_oe_n = !(serial_enable && sdo_drive); // [R7]
  assign cs_rise = serial_enable && !cs_q && cs_n; // [R7]
  assign wr_acc = cs_rise && frame_valid;
  assign data_wr = wr_acc && (frame_target == TGT_DATA);
  assign offset_dac_enable = !single_supply; // [R4]
  assign rst_code = reset_code(reset_value_select, input_format_select); // [R3] [R4]
  assign rst_offset = input_format_select ? OFFSET_TC : OFFSET_SB; // [R3]

  // timer link; a load waits while the engine still owes data registers
  assign lif.cs_rise = cs_rise;
  assign lif.sync_mode = sync_mode;
  assign lif.in_reset = in_reset;
  assign lif.hold = (busy != '0) || corr_start || (data_wr && correction_engine_enable); // [R17]

  // next values of strap, engine handshake and offsets
  always_comb begin
    next_cs_q = cs_n;
    next_por_done = por_done;
    next_sync_mode = sync_mode;
    next_corr_start = 1'b0;
    next_corr_ch = corr_ch;
    next_corr_code = corr_code;
    next_busy = busy;
    next_offset = offset_code_a;
    if (!por_done) begin
      next_por_done = 1'b1;
      next_sync_mode = latch_load_strobe_n; // [R10]
    end
    if (data_wr && correction_engine_enable) begin
      next_corr_start = 1'b1; // [R15] [R17]
      next_corr_ch = frame_ch;
      next_corr_code = frame_data;
    end
    next_busy = busy + BUSY_W'(corr_start) - BUSY_W'(corr_done && (busy != '0));
    if (in_reset) begin
      next_offset = rst_offset; // [R1] [R3]
      next_corr_start = 1'b0;
      next_busy = '0;
    end
  end

  // register stage; the strap is caught on the first edge after power-on release
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      cs_q <= 1'b1;
      por_done <= 1'b0;
      sync_mode <= 1'b0;
      corr_start <= 1'b0;
      corr_ch <= '0;
      corr_code <= CODE_ZERO;
      busy <= '0;
      offset_code_a <= rst_offset; // [R1]
      offset_code_b <= rst_offset;
    end else if (clk_en) begin
      cs_q <= next_cs_q;
      por_done <= next_por_done;
      sync_mode <= next_sync_mode;
      corr_start <= next_corr_start;
      corr_ch <= next_corr_ch;
      corr_code <= next_corr_code;
      busy <= next_busy;
      offset_code_a <= next_offset;
      offset_code_b <= next_offset;
    end
  end

  // per-channel registers, latches and pending flags
  for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
    logic wr_hit;
    logic direct;
    logic eng_hit;
    logic upd_src;
    code_t new_code;
    code_t next_input;
    code_t next_data;
    code_t next_latch;
    code_t next_gain;
    code_t next_zero;
    logic next_pend;

    assign wr_hit = wr_acc && (frame_ch == CH_W'(i));
    assign direct = wr_hit && (frame_target == TGT_DATA) && !correction_engine_enable;
    assign eng_hit = corr_done && (corr_done_ch == CH_W'(i));
    assign upd_src = direct || eng_hit;
    assign new_code = direct ? frame_data : corr_result;
    assign latch_upd[i] = !in_reset && (sync_mode ? (lif.fire && pending[i]) : upd_src); // [R18]

    // next values for one channel
    always_comb begin
      next_input = input_code[i];
      next_data = data_code[i];
      next_latch = latch_code[i];
      next_gain = gain_code[i];
      next_zero = zero_code[i];
      next_pend = pending[i];
      if (wr_hit && (frame_target == TGT_DATA)) begin
        next_input = frame_data;
      end
      if (wr_hit && (frame_target == TGT_GAIN)) begin
        next_gain = frame_data;
      end
      if (wr_hit && (frame_target == TGT_ZERO)) begin
        next_zero = frame_data;
      end
      if (upd_src) begin
        next_data = new_code;
      end
      if (!sync_mode && upd_src) begin
        next_latch = new_code; // [R12] [R14] [R15]
      end else if (latch_upd[i]) begin
        next_latch = data_code[i]; // [R11] [R16] [R17]
      end
      if (sync_mode && upd_src) begin
        next_pend = 1'b1; // [R20] a write in the load cycle stays pending
      end else if (latch_upd[i]) begin
        next_pend = 1'b0; // [R11]
      end
      if (in_reset) begin
        next_input = INPUT_RESET; // [R2]
        next_data = rst_code; // [R1] [R6]
        next_latch = rst_code; // [R1] [R6]
        next_gain = GAIN_DEFAULT; // [R5] [R6]
        next_zero = ZERO_DEFAULT; // [R5] [R6]
        next_pend = 1'b0;
      end
    end

    // register stage for one channel
    always_ff @(posedge sys_clk) begin
      if (clk_en) begin
        input_code[i] <= next_input;
        data_code[i] <= next_data;
        latch_code[i] <= next_latch;
        gain_code[i] <= next_gain;
        zero_code[i] <= next_zero;
        pending[i] <= next_pend;
      end
    end
  end

  // checks
  default clocking cb @(posedge sys_clk);
  endclocking

  // reset and power-on values
  chk_por_values: assert property ((!rstn && clk_en) |=> // [R1]
    latch_code[3] == reset_code($past(reset_value_select), $past(input_format_select)))
    else $error("latch not at reset code after power-on");
  chk_input_clear: assert property ((in_reset && clk_en) |=> input_code[5] == INPUT_RESET) // [R2]
    else $error("input register not cleared in reset");
  chk_offset_code: assert property ((in_reset && clk_en) |=> // [R3]
    offset_code_a == ($past(input_format_select) ? OFFSET_TC : OFFSET_SB))
    else $error("offset code wrong after reset");
  chk_offset_off: assert property (offset_dac_enable == !single_supply) // [R4]
    else $error("offset enable does not follow supply mode");
  chk_gain_default: assert property ((in_reset && clk_en) |=> // [R6]
    gain_code[2] == GAIN_DEFAULT && zero_code[7] == ZERO_DEFAULT)
    else $error("gain or zero not at default after reset");
  chk_serial_off: assert property (!hw_reset_n |-> !serial_enable && sdo_oe_n && !cs_rise) // [R7]
    else $error("serial port active in reset");
  chk_por_gain: assert property ((!rstn && clk_en) |=> // [R5]
    gain_code[0] == GAIN_DEFAULT && zero_code[0] == ZERO_DEFAULT)
    else $error("gain or zero not at default after power-on");

  // update mode and latch paths
  chk_latch_hold: assert property (disable iff (!rstn) // [R8]
    (!in_reset && clk_en && latch_upd == '0) |=> $stable(latch_code[1]) && $stable(latch_code[6]))
    else $error("latch changed without update");
  chk_mode_strap: assert property (disable iff (!rstn) (clk_en && por_done) |=> $stable(sync_mode)) // [R10]
    else $error("update mode changed after power-on");
  chk_async_ignore: assert property (!sync_mode |-> !lif.fire) // [R13]
    else $error("load fired in asynchronous mode");
  chk_async_direct: assert property (disable iff (in_reset) // [R14]
    (clk_en && !sync_mode && data_wr && !correction_engine_enable) |=>
    latch_code[$past(frame_ch)] == $past(frame_data))
    else $error("async write did not reach latch");
  chk_async_engine: assert property (disable iff (in_reset) // [R15]
    (clk_en && !sync_mode && corr_done) |=> latch_code[$past(corr_done_ch)] == $past(corr_result))
    else $error("engine result did not reach latch");
  chk_sync_load: assert property (disable iff (in_reset) // [R16]
    (clk_en && sync_mode && lif.fire && pending[0]) |=> latch_code[0] == $past(data_code[0]))
    else $error("pending channel not loaded");
  chk_engine_wait: assert property (lif.fire |-> busy == '0 && !corr_start) // [R17]
    else $error("load while engine busy");
  chk_t9_delay: assert property (disable iff (in_reset) (cs_rise && clk_en) |=> !lif.fire [*5]) // [R20]
    else $error("load inside chip select spacing");
  chk_no_reload: assert property (disable iff (in_reset) // [R11]
    (clk_en && sync_mode && lif.fire && !pending[5]) |=> $stable(latch_code[5]))
    else $error("latch reloaded without a pending write");
  chk_pend_clear: assert property (disable iff (in_reset) // [R11]
    (clk_en && sync_mode && lif.fire && pending[1] && !data_wr && !corr_done) |=> !pending[1])
    else $error("pending flag kept after load");
  chk_sync_hold: assert property (disable iff (in_reset) // [R18]
    (clk_en && sync_mode && !lif.fire) |=> $stable(latch_code[4]))
    else $error("latch changed without a load");
  chk_pend_set: assert property (disable iff (in_reset) // [R20]
    (clk_en && sync_mode && data_wr && !correction_engine_enable) |=> pending[$past(frame_ch)])
    else $error("written channel not pending");
  chk_engine_start: assert property (disable iff (in_reset) // [R15]
    (clk_en && data_wr && correction_engine_enable) |=> corr_start && corr_ch == $past(frame_ch))
    else $error("engine job not started");

  // covers for the main scenarios
  cov_async_write: cover property (!sync_mode && data_wr && !correction_engine_enable);
  cov_sync_load: cover property (sync_mode && lif.fire && pending != '0);
  cov_engine_wait: cover property (sync_mode && lif.hold && busy != '0 ##[1:20] lif.fire);
  cov_hw_reset: cover property (rstn && $rose(hw_reset_n));
  cov_sw_load: cover property (sync_mode && software_load_bit);
endmodule

/* File: core/dac_rst_pkg.sv */
package dac_rst_pkg;
  localparam int NUM_CH = 8;
  localparam int CODE_W = 14;
  localparam int CH_W = 3;
  localparam int BUSY_W = 4;
  typedef logic [CODE_W-1:0] code_t;
  typedef logic [CH_W-1:0] chan_t;
  // destination of a decoded serial frame
  typedef enum logic [1:0] {TGT_DATA, TGT_GAIN, TGT_ZERO, TGT_NONE} target_t;
  // reset codes
  localparam code_t CODE_ZERO = 14'h0000;
  localparam code_t CODE_MID = 14'h2000;
  localparam code_t OFFSET_SB = 14'h2666;
  localparam code_t OFFSET_TC = 14'h0666;
  localparam code_t INPUT_RESET = 14'h0000;
  localparam code_t GAIN_DEFAULT = 14'h3fff;
  localparam code_t ZERO_DEFAULT = 14'h2000;
  // chip-select-rise to load spacing
  localparam int CLK_PERIOD_PS = 10000;
  localparam int T9_MIN_NS = 50;
  localparam int T9_CYCLES_RAW = (T9_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int T9_CYCLES = (T9_CYCLES_RAW < 1) ? 1 : T9_CYCLES_RAW;
  localparam int CNT_W = 4;
  localparam logic [CNT_W-1:0] T9_LOAD = CNT_W'(T9_CYCLES);
  // data and latch reset code from the select and format pins
  function automatic code_t reset_code(input logic sel, input logic fmt);
    return (sel ^ fmt) ? CODE_MID : CODE_ZERO;
  endfunction
endpackage

/* File: core/load_if.sv */
`timescale 1ns/1ps
interface load_if;
  logic cs_rise;
  logic sync_mode;
  logic in_reset;
  logic hold;
  logic fire;
  modport timer(input cs_rise, input sync_mode, input in_reset, input hold, output fire);
  modport ctrl(output cs_rise, output sync_mode, output in_reset, output hold, input fire);
endinterface

/* File: core/load_timer.sv */
`timescale 1ns/1ps
module load_timer (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic clk_en,
  // load triggers
  input wire logic latch_load_strobe_n,
  input wire logic software_load_bit,
  // link to the controller
  load_if.timer lif
);
  import dac_rst_pkg::*;

  logic strobe_q;
  logic req;
  logic [CNT_W-1:0] cnt;
  logic next_strobe_q;
  logic next_req;
  logic [CNT_W-1:0] next_cnt;
  logic new_req;

  // load request is held until the spacing count has run out and the engine is idle
  assign new_req = lif.sync_mode && ((strobe_q && !latch_load_strobe_n) || software_load_bit);
  assign lif.fire = req && (cnt == '0) && !lif.hold && !lif.cs_rise && lif.sync_mode && !lif.in_reset;

  // next values of strobe history, request and spacing counter
  always_comb begin
    next_strobe_q = latch_load_strobe_n;
    next_req = req;
    next_cnt = cnt;
    if (lif.cs_rise) begin
      next_cnt = T9_LOAD; // [R20]
    end else if (cnt != '0) begin
      next_cnt = cnt - 1'b1;
    end
    if (lif.in_reset || !lif.sync_mode) begin
      next_req = 1'b0; // [R13]
    end else if (new_req) begin
      next_req = 1'b1; // [R16] new request wins over the fire clear
    end else if (lif.fire) begin
      next_req = 1'b0;
    end
    if (lif.in_reset) begin
      next_cnt = '0;
    end
  end

  // register stage
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      strobe_q <= 1'b1;
      req <= 1'b0;
      cnt <= '0;
    end else if (clk_en) begin
      strobe_q <= next_strobe_q;
      req <= next_req;
      cnt <= next_cnt;
    end
  end
endmodule

/* File: tb/dac_reset_and_latch_update_tb_top.sv */
`timescale 1ns/1ps
module dac_reset_and_latch_update_tb_top;
  import dac_rst_pkg::*;
  logic sys_clk = 1'b0, rstn = 1'b0, clk_en = 1'b1, sdo_drive = 1'b1;
  logic sel = 1'b0, fmt = 1'b0, ss = 1'b0, ce = 1'b0;
  logic hw_reset_n, strobe_n, swl, cs_n, fvalid, corr_start, corr_done;
  logic serial_enable, sdo_oe_n, sync_mode, offset_dac_enable;
  logic [NUM_CH-1:0] pending;
  target_t ftgt;
  chan_t fch, corr_ch, done_ch;
  code_t fdata, corr_code, corr_result, off_a, off_b;
  code_t input_code [NUM_CH], data_code [NUM_CH], latch_code [NUM_CH];
  code_t gain_code [NUM_CH], zero_code [NUM_CH];
  code_t exp;
  int errors = 0, samples_checked = 0;
  // clock
  always #5 sys_clk = ~sys_clk;
  dac_reset_latch_ctrl i_dut (.sys_clk(sys_clk), .rstn(rstn), .clk_en(clk_en), .hw_reset_n(hw_reset_n),
    .reset_value_select(sel), .input_format_select(fmt), .single_supply(ss), .latch_load_strobe_n(strobe_n),
    .software_load_bit(swl), .correction_engine_enable(ce), .cs_n(cs_n), .frame_valid(fvalid),
    .frame_target(ftgt), .frame_ch(fch), .frame_data(fdata), .sdo_drive(sdo_drive), .corr_start(corr_start),
    .corr_ch(corr_ch), .corr_code(corr_code), .corr_done(corr_done), .corr_done_ch(done_ch),
    .corr_result(corr_result), .serial_enable(serial_enable), .sdo_oe_n(sdo_oe_n), .sync_mode(sync_mode),
    .offset_dac_enable(offset_dac_enable), .offset_code_a(off_a), .offset_code_b(off_b),
    .input_code(input_code), .data_code(data_code), .latch_code(latch_code), .gain_code(gain_code),
    .zero_code(zero_code), .pending(pending));
  host_model i_host (.sys_clk(sys_clk), .hw_reset_n(hw_reset_n), .latch_load_strobe_n(strobe_n),
    .software_load_bit(swl), .cs_n(cs_n), .frame_valid(fvalid), .frame_target(ftgt), .frame_ch(fch),
    .frame_data(fdata), .corr_start(corr_start), .corr_ch(corr_ch), .corr_code(corr_code),
    .corr_done(corr_done), .corr_done_ch(done_ch), .corr_result(corr_result));
  // comparisons
  task automatic check_code(input code_t got, input code_t want);
    samples_checked++;
    if (got !== want) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask
  task automatic check_bit(input logic got, input logic want);
    check_code({13'h0000, got}, {13'h0000, want});
  endtask
  // power-on with strap level for the update mode
  task automatic power_on(input logic lvl);
    i_host.set_strobe(lvl);
    rstn <= 1'b0;
    repeat (12) @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (2) @(posedge sys_clk);
    #1;
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // watchdog
  initial begin
    #200000;
    errors++;
    stop_test();
  end
  // test sequence
  initial begin
    sel <= 1'b1;
    power_on(1'b0);
    check_code(data_code[0], 14'h2000);
    check_code(latch_code[7], 14'h2000);
    check_code(off_b, 14'h2666);
    check_bit(sync_mode, 1'b0);
    for (int i = 0; i < 8; i++) begin
      i_host.send(i[2:0], 14'h1555);
      i_host.send_to(TGT_GAIN, i[2:0], 14'h0042);
      i_host.send_to(TGT_ZERO, i[2:0], 14'h0024);
      sel <= i[0];
      fmt <= i[1];
      ss <= i[2];
      i_host.set_reset(1'b0);
      i_host.send(3'h5, 14'h0555);
      #1;
      exp = (i[0] ^ i[1]) ? 14'h2000 : 14'h0000;
      check_bit(serial_enable, 1'b0);
      check_bit(sdo_oe_n, 1'b1);
      check_bit(offset_dac_enable, ~i[2]);
      check_code(off_a, i[1] ? 14'h0666 : 14'h2666);
      for (int c = 0; c < NUM_CH; c++) begin
        check_code(data_code[c], exp);
        check_code(latch_code[c], exp);
        check_code(input_code[c], 14'h0000);
        check_code(gain_code[c], 14'h3fff);
        check_code(zero_code[c], 14'h2000);
      end
      i_host.set_reset(1'b1);
    end
    repeat (4) @(posedge sys_clk);
    #1;
    check_code(latch_code[0], 14'h0000);
    check_bit(sdo_oe_n, 1'b0);
    $display("test reset_table done");
    i_host.send(3'h2, 14'h0abc);
    #1;
    check_code(latch_code[2], 14'h0abc);
    i_host.strobe_load();
    i_host.sw_load();
    #1;
    check_code({6'h00, pending}, 14'h0000);
    check_code(latch_code[2], 14'h0abc);
    ce <= 1'b1;
    i_host.send(3'h3, 14'h0123);
    #1;
    check_code(latch_code[3], 14'h0000);
    repeat (12) @(posedge sys_clk);
    #1;
    check_code(data_code[3], 14'h0122);
    check_code(latch_code[3], 14'h0122);
    ce <= 1'b0;
    $display("test async_mode done");
    sel <= 1'b1;
    fmt <= 1'b0;
    power_on(1'b1);
    check_bit(sync_mode, 1'b1);
    i_host.send(3'h1, 14'h1111);
    i_host.send(3'h4, 14'h0444);
    #1;
    check_code({6'h00, pending}, 14'h0012);
    repeat (5) @(posedge sys_clk);
    #1;
    check_code(latch_code[1], 14'h2000);
    i_host.strobe_load();
    repeat (3) @(posedge sys_clk);
    #1;
    check_code(latch_code[1], 14'h1111);
    check_code(latch_code[4], 14'h0444);
    check_code(latch_code[5], 14'h2000);
    check_code({6'h00, pending}, 14'h0000);
    ce <= 1'b1;
    i_host.send(3'h6, 14'h0600);
    i_host.sw_load();
    #1;
    check_code(latch_code[6], 14'h2000);
    repeat (12) @(posedge sys_clk);
    #1;
    check_code(latch_code[6], 14'h0601);
    check_code(latch_code[1], 14'h1111);
    $display("test sync_mode done");
    stop_test();
  end
endmodule

/* File: tb/host_model.sv */
`timescale 1ns/1ps
// host pins and a slow correction engine
module host_model (
  // clock
  input wire logic sys_clk,
  // reset and load pins
  output logic hw_reset_n,
  output logic latch_load_strobe_n,
  output logic software_load_bit,
  // decoded serial frame
  output logic cs_n,
  output logic frame_valid,
  output dac_rst_pkg::target_t frame_target,
  output dac_rst_pkg::chan_t frame_ch,
  output dac_rst_pkg::code_t frame_data,
  // correction engine
  input wire logic corr_start,
  input wire dac_rst_pkg::chan_t corr_ch,
  input wire dac_rst_pkg::code_t corr_code,
  output logic corr_done,
  output dac_rst_pkg::chan_t corr_done_ch,
  output dac_rst_pkg::code_t corr_result
);
  import dac_rst_pkg::*;
  int busy;
  chan_t ch_q;
  code_t code_q;
  // idle pin levels
  initial begin
    hw_reset_n = 1'b1;
    latch_load_strobe_n = 1'b1;
    software_load_bit = 1'b0;
    cs_n = 1'b1;
    frame_valid = 1'b0;
    frame_target = TGT_DATA;
    frame_ch = '0;
    frame_data = '0;
    corr_done = 1'b0;
    corr_done_ch = '0;
    corr_result = '0;
    busy = 0;
  end
  // one frame to a target; data inverted outside the decode cycle
  task automatic send_to(input target_t tgt, input chan_t ch, input code_t d);
    @(posedge sys_clk);
    cs_n <= 1'b0;
    frame_data <= ~d;
    @(posedge sys_clk);
    cs_n <= 1'b1;
    frame_valid <= 1'b1;
    frame_target <= tgt;
    frame_ch <= ch;
    frame_data <= d;
    @(posedge sys_clk);
    frame_valid <= 1'b0;
    frame_data <= d ^ 14'h3fff;
  endtask
  // data register frame
  task automatic send(input chan_t ch, input code_t d);
    send_to(TGT_DATA, ch, d);
  endtask
  // reset pin only; chip select left at its level, the test sends a frame during reset
  task automatic set_reset(input logic lvl);
    @(posedge sys_clk);
    hw_reset_n <= lvl;
  endtask
  // strap level held before and during power-on
  task automatic set_strobe(input logic lvl);
    @(posedge sys_clk);
    latch_load_strobe_n <= lvl;
  endtask
  // strobe load after the chip-select spacing
  task automatic strobe_load();
    repeat (T9_CYCLES) @(posedge sys_clk);
    latch_load_strobe_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    latch_load_strobe_n <= 1'b1;
  endtask
  // software load pulse after the spacing
  task automatic sw_load();
    repeat (T9_CYCLES) @(posedge sys_clk);
    software_load_bit <= 1'b1;
    @(posedge sys_clk);
    software_load_bit <= 1'b0;
  endtask
  // engine answers eight cycles after a job, result is code xor 1
  always @(posedge sys_clk) begin
    if (!corr_start && busy == 1) begin
      corr_done <= 1'b1;
      corr_done_ch <= ch_q;
      corr_result <= code_q ^ 14'h0001;
    end else begin
      corr_done <= 1'b0;
      corr_result <= ~corr_result;
    end
    if (corr_start) begin
      busy <= 8;
      ch_q <= corr_ch;
      code_q <= corr_code;
    end else if (busy != 0) begin
      busy <= busy - 1;
    end
  end
endmodule
